//--- pkg/sbl_defines.vh
// Shared constants of the serial boot loader
`ifndef SBL_DEFINES_VH
`define SBL_DEFINES_VH

// ==========================================================
// Link protocol codes
`define SBL_MODE_ASYNC 8'h86
`define SBL_MODE_SYNC 8'h30
`define SBL_CMD_RAM 8'h10
`define SBL_CMD_SUM 8'h20
`define SBL_CMD_INFO 8'h30
`define SBL_NAK_LO 4'h1
`define SBL_ERR_LO 4'h8
`define SBL_ERASED_BYTE 8'hFF

// ==========================================================
// Sequence counts
`define SBL_PW_LAST 4'hB
`define SBL_HDR_LAST 3'h5
`define SBL_CNT_W 16
`define SBL_MIN_BITP 16'h0002

// ==========================================================
// Frame layout
`define SBL_IDX_START 4'h0
`define SBL_IDX_DATA0 4'h1
`define SBL_IDX_ARMED 4'h2
`define SBL_IDX_LAST 4'h8
`define SBL_IDX_STOP 4'h9

// ==========================================================
// Buffer shape
`define SBL_FIFO_W 8
`define SBL_FIFO_D 32

`endif

//--- hdl/sbl_fifo.v
// Byte FIFO between the serial receiver and the RAM writer
`timescale 1ns/100ps
`default_nettype none
`include "sbl_defines.vh"

module sbl_fifo #(
    parameter W = `SBL_FIFO_W,
    parameter D = `SBL_FIFO_D,
    parameter AW = 5
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

    reg [W-1:0] mem [0:D-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire [AW:0] used = wr_q - rd_q;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    assign in_ready = (used != D[AW:0]);
    assign out_valid = (used != {(AW+1){1'b0}});
    assign out_data = mem[rd_q[AW-1:0]];

    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

//--- hdl/sbl_loader.v
// Boot-mode capture and single-boot serial loader
//
// Behaviour
// - Single boot maps the boot ROM over vectors and moves flash elsewhere.
// - Serial channel zero carries every command and data byte to and from host.
// - Password is checked before any routine byte reaches RAM.
// - Twelve received password bytes are compared against flash password locations.
// - An erased password block expects all-ones bytes.
// - Password mismatch aborts the routine transfer completely.
// - On match the routine bytes are received and written into RAM.
// - After the jump to the RAM routine the boot ROM never regains control.
// - All interrupts, NMI included, are masked during flash erase or program.
// - Flash stays in normal mode while boot ROM code runs.
// - No erase of the old application is needed before the routine runs.
// - After reprogramming, the affected flash blocks are flagged for protection.
// - User boot is chosen at reset release from a user condition.
// - Any reset that does not select user boot returns flash to normal mode, running the new application.
// - Async link: full duplex, 8 data bits, no parity, 1 stop, host baud.
// - First byte 86H or 30H picks the serial mode and is echoed.
// - Command codes 10H, 20H and 30H are accepted.
`timescale 1ns/100ps
`default_nettype none
`include "sbl_defines.vh"

module sbl_loader #(
    parameter CW = `SBL_CNT_W,
    parameter [7:0] PROD_INFO = 8'h5A  // Arbitrary product information value
) (
    // Clock and reset
    input wire core_clk,
    input wire rst,
    // Mode straps
    input wire boot_sel_n,
    input wire user_boot_cond,
    // Serial channel zero
    input wire serial_channel_zero_rxd,
    output wire serial_channel_zero_txd,
    // Flash side information
    input wire [95:0] flash_pw,
    input wire pw_block_erased,
    input wire [15:0] flash_sum,
    input wire flash_busy,
    input wire prog_complete,
    // RAM write port
    output wire ram_we,
    output wire [31:0] ram_addr,
    output wire [7:0] ram_wdata,
    input wire ram_ready,
    // Mode and status outputs
    output wire single_boot_mode,
    output wire user_boot_mode,
    output wire boot_rom_map,
    output wire flash_remap,
    output wire flash_normal_mode,
    output wire irq_global_disable,
    output wire flash_protect_req,
    output wire ram_exec_start,
    output wire loader_abort
);

    // ==========================================================
    // States
    localparam [11:0] ST_WAIT = 12'h001;
    localparam [11:0] ST_MEAS = 12'h002;
    localparam [11:0] ST_MODE = 12'h004;
    localparam [11:0] ST_CMD = 12'h008;
    localparam [11:0] ST_PW = 12'h010;
    localparam [11:0] ST_CHK = 12'h020;
    localparam [11:0] ST_HDR = 12'h040;
    localparam [11:0] ST_DATA = 12'h080;
    localparam [11:0] ST_DRAIN = 12'h100;
    localparam [11:0] ST_REPLY = 12'h200;
    localparam [11:0] ST_RUN = 12'h400;
    localparam [11:0] ST_ABORT = 12'h800;

    // ==========================================================
    // Mode capture at reset release
    reg rst_prev_q;
    reg single_q;
    reg user_q;
    reg protect_q;
    reg irq_off_q;
    reg rxd_prev_q;

    always @(posedge core_clk) begin
        rst_prev_q <= rst;
        rxd_prev_q <= serial_channel_zero_rxd;
        if (rst) begin
            single_q <= 1'b0;
            user_q <= 1'b0;
            protect_q <= 1'b0;
            irq_off_q <= 1'b0;
        end else begin
            // Strap caught on the first clock after release, then frozen
            if (rst_prev_q) begin
                single_q <= ~boot_sel_n;
                user_q <= boot_sel_n & user_boot_cond;
            end
            if (prog_complete) begin
                protect_q <= 1'b1;
            end
            irq_off_q <= user_q | flash_busy;
        end
    end

    // ==========================================================
    // Receiver and transmitter
    reg [11:0] st_q;
    reg [CW-1:0] meas_q;
    reg [CW-1:0] bitp_q;
    reg rx_act_q;
    reg [CW-1:0] rx_cnt_q;
    reg [3:0] rx_idx_q;
    reg [7:0] rx_sh_q;
    reg rx_vld_q;
    reg rx_ferr_q;
    reg tx_act_q;
    reg [CW-1:0] tx_cnt_q;
    reg [3:0] tx_idx_q;
    reg [8:0] tx_sh_q;
    reg txd_q;
    reg [23:0] rep_q;
    reg [1:0] rep_n_q;

    wire rxd = serial_channel_zero_rxd;
    wire fall = rxd_prev_q & ~rxd;
    // 86H starts with two low bit times: the low span gives twice the bit period
    wire arm = (st_q == ST_MEAS) & rxd & (meas_q >= (`SBL_MIN_BITP << 1));
    wire rx_en = single_q & (st_q != ST_WAIT) & (st_q != ST_MEAS) & (st_q != ST_RUN);
    wire tx_go = (st_q == ST_REPLY) & ~tx_act_q & (rep_n_q != 2'b00);

    always @(posedge core_clk) begin
        if (rst) begin
            rx_act_q <= 1'b0;
            rx_cnt_q <= {CW{1'b0}};
            rx_idx_q <= `SBL_IDX_START;
            rx_sh_q <= 8'h00;
            rx_vld_q <= 1'b0;
            rx_ferr_q <= 1'b0;
        end else begin
            rx_vld_q <= 1'b0;
            if (arm) begin
                // Resume mid-frame: start and bit 0 were both low
                rx_act_q <= 1'b1;
                rx_idx_q <= `SBL_IDX_ARMED;
                rx_cnt_q <= meas_q >> 2;
                rx_sh_q <= 8'h00;
            end else if (!rx_act_q) begin
                if (rx_en && fall) begin
                    rx_act_q <= 1'b1;
                    rx_idx_q <= `SBL_IDX_START;
                    rx_cnt_q <= bitp_q >> 1;
                end
            end else if (rx_cnt_q == {CW{1'b0}}) begin
                rx_cnt_q <= bitp_q - 1'b1;
                if (rx_idx_q == `SBL_IDX_START) begin
                    rx_act_q <= ~rxd;
                    rx_idx_q <= `SBL_IDX_DATA0;
                end else if (rx_idx_q <= `SBL_IDX_LAST) begin
                    rx_sh_q <= {rxd, rx_sh_q[7:1]};
                    rx_idx_q <= rx_idx_q + 1'b1;
                end else begin
                    rx_act_q <= 1'b0;
                    rx_vld_q <= 1'b1;
                    rx_ferr_q <= ~rxd;
                end
            end else begin
                rx_cnt_q <= rx_cnt_q - 1'b1;
            end
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            tx_act_q <= 1'b0;
            tx_cnt_q <= {CW{1'b0}};
            tx_idx_q <= `SBL_IDX_START;
            tx_sh_q <= 9'h1FF;
            txd_q <= 1'b1;
        end else if (tx_go) begin
            tx_act_q <= 1'b1;
            tx_cnt_q <= bitp_q - 1'b1;
            tx_idx_q <= `SBL_IDX_START;
            tx_sh_q <= {1'b1, rep_q[23:16]};
            txd_q <= 1'b0;
        end else if (tx_act_q) begin
            if (tx_cnt_q == {CW{1'b0}}) begin
                tx_cnt_q <= bitp_q - 1'b1;
                if (tx_idx_q == `SBL_IDX_STOP) begin
                    tx_act_q <= 1'b0;
                end else begin
                    txd_q <= tx_sh_q[0];
                    tx_sh_q <= {1'b1, tx_sh_q[8:1]};
                    tx_idx_q <= tx_idx_q + 1'b1;
                end
            end else begin
                tx_cnt_q <= tx_cnt_q - 1'b1;
            end
        end
    end

    // ==========================================================
    // Loader sequence and RAM writer
    reg [11:0] ret_q;
    reg [3:0] pw_idx_q;
    reg [7:0] sum_q;
    reg mism_q;
    reg [2:0] hdr_idx_q;
    reg [39:0] hdr_q;
    reg [31:0] base_q;
    reg [15:0] left_q;
    reg [31:0] off_q;
    reg ram_we_q;
    reg [31:0] ram_addr_q;
    reg [7:0] ram_wdata_q;

    wire [7:0] pw_exp = pw_block_erased ? `SBL_ERASED_BYTE : flash_pw[pw_idx_q*8 +: 8];
    wire [7:0] err_code = {rx_sh_q[7:4], `SBL_ERR_LO};
    wire fifo_in_rdy;
    wire fifo_out_vld;
    wire [7:0] fifo_out_data;
    wire fifo_push = (st_q == ST_DATA) & rx_vld_q & ~rx_ferr_q & fifo_in_rdy;
    wire fifo_pop = fifo_out_vld & (~ram_we_q | ram_ready);

    always @(posedge core_clk) begin
        if (rst) begin
            st_q <= ST_WAIT;
            ret_q <= ST_CMD;
            meas_q <= {CW{1'b0}};
            bitp_q <= `SBL_MIN_BITP;
            rep_q <= 24'h000000;
            rep_n_q <= 2'b00;
            pw_idx_q <= 4'h0;
            sum_q <= 8'h00;
            mism_q <= 1'b0;
            hdr_idx_q <= 3'h0;
            hdr_q <= 40'h0000000000;
            base_q <= 32'h00000000;
            left_q <= 16'h0000;
        end else begin
            if (tx_go) begin
                rep_q <= {rep_q[15:0], 8'h00};
                rep_n_q <= rep_n_q - 1'b1;
            end
            case (st_q)
                ST_WAIT: begin
                    if (single_q && !rst_prev_q && fall) begin
                        meas_q <= {{(CW-1){1'b0}}, 1'b1};
                        st_q <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (!rxd) begin
                        if (meas_q != {CW{1'b1}}) begin
                            meas_q <= meas_q + 1'b1;
                        end
                    end else if (arm) begin
                        bitp_q <= meas_q >> 1;
                        st_q <= ST_MODE;
                    end else begin
                        st_q <= ST_ABORT;
                    end
                end
                ST_MODE: begin
                    if (rx_vld_q) begin
                        if (rx_ferr_q) begin
                            st_q <= ST_ABORT;
                        end else if (rx_sh_q == `SBL_MODE_ASYNC) begin
                            rep_q <= {rx_sh_q, 16'h0000};
                            rep_n_q <= 2'b01;
                            ret_q <= ST_CMD;
                            st_q <= ST_REPLY;
                        end else if (rx_sh_q == `SBL_MODE_SYNC) begin
                            // Clocked-link transfers are not built: echo, then stop
                            rep_q <= {rx_sh_q, 16'h0000};
                            rep_n_q <= 2'b01;
                            ret_q <= ST_ABORT;
                            st_q <= ST_REPLY;
                        end else begin
                            st_q <= ST_ABORT;
                        end
                    end
                end
                ST_CMD: begin
                    if (rx_vld_q) begin
                        st_q <= ST_REPLY;
                        ret_q <= ST_CMD;
                        rep_n_q <= 2'b01;
                        if (rx_ferr_q) begin
                            rep_q <= {err_code, 16'h0000};
                        end else begin
                            case (rx_sh_q)
                                `SBL_CMD_RAM: begin
                                    rep_q <= {rx_sh_q, 16'h0000};
                                    ret_q <= ST_PW;
                                    pw_idx_q <= 4'h0;
                                    sum_q <= 8'h00;
                                    mism_q <= 1'b0;
                                end
                                `SBL_CMD_SUM: begin
                                    rep_q <= {rx_sh_q, flash_sum};
                                    rep_n_q <= 2'b11;
                                end
                                `SBL_CMD_INFO: begin
                                    rep_q <= {rx_sh_q, PROD_INFO, 8'h00};
                                    rep_n_q <= 2'b10;
                                end
                                default: begin
                                    rep_q <= {rx_sh_q[7:4], `SBL_NAK_LO, 16'h0000};
                                end
                            endcase
                        end
                    end
                end
                ST_PW: begin
                    if (rx_vld_q) begin
                        if (rx_ferr_q) begin
                            rep_q <= {err_code, 16'h0000};
                            rep_n_q <= 2'b01;
                            ret_q <= ST_CMD;
                            st_q <= ST_REPLY;
                        end else begin
                            sum_q <= sum_q + rx_sh_q;
                            mism_q <= mism_q | (rx_sh_q != pw_exp);
                            pw_idx_q <= pw_idx_q + 1'b1;
                            if (pw_idx_q == `SBL_PW_LAST) begin
                                st_q <= ST_CHK;
                            end
                        end
                    end
                end
                ST_CHK: begin
                    if (rx_vld_q) begin
                        st_q <= ST_REPLY;
                        rep_n_q <= 2'b01;
                        ret_q <= ST_CMD;
                        if (rx_ferr_q) begin
                            rep_q <= {`SBL_CMD_RAM | {4'h0, `SBL_ERR_LO}, 16'h0000};
                        end else if ((sum_q + rx_sh_q) != 8'h00) begin
                            rep_q <= {`SBL_CMD_RAM | {4'h0, `SBL_NAK_LO}, 16'h0000};
                        end else if (mism_q) begin
                            st_q <= ST_ABORT;
                        end else begin
                            rep_q <= {`SBL_CMD_RAM, 16'h0000};
                            ret_q <= ST_HDR;
                            hdr_idx_q <= 3'h0;
                        end
                    end
                end
                ST_HDR: begin
                    if (rx_vld_q) begin
                        hdr_q <= {hdr_q[31:0], rx_sh_q};
                        hdr_idx_q <= hdr_idx_q + 1'b1;
                        if (rx_ferr_q) begin
                            st_q <= ST_ABORT;
                        end else if (hdr_idx_q == `SBL_HDR_LAST) begin
                            base_q <= hdr_q[39:8];
                            left_q <= {hdr_q[7:0], rx_sh_q};
                            st_q <= ({hdr_q[7:0], rx_sh_q} == 16'h0000) ? ST_DRAIN : ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (rx_vld_q) begin
                        // The line cannot be paused: a full buffer is an overrun
                        if (rx_ferr_q || !fifo_in_rdy) begin
                            st_q <= ST_ABORT;
                        end else begin
                            left_q <= left_q - 1'b1;
                            if (left_q == 16'h0001) begin
                                st_q <= ST_DRAIN;
                            end
                        end
                    end
                end
                ST_DRAIN: begin
                    if (!fifo_out_vld && !ram_we_q) begin
                        st_q <= ST_RUN;
                    end
                end
                ST_REPLY: begin
                    if (rep_n_q == 2'b00 && !tx_act_q) begin
                        st_q <= ret_q;
                    end
                end
                ST_RUN: begin
                    st_q <= ST_RUN;
                end
                ST_ABORT: begin
                    st_q <= ST_ABORT;
                end
                default: begin
                    st_q <= ST_ABORT;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            off_q <= 32'h00000000;
            ram_we_q <= 1'b0;
            ram_addr_q <= 32'h00000000;
            ram_wdata_q <= 8'h00;
        end else begin
            if (st_q == ST_HDR) begin
                off_q <= 32'h00000000;
            end
            if (fifo_pop) begin
                ram_we_q <= 1'b1;
                ram_addr_q <= base_q + off_q;
                ram_wdata_q <= fifo_out_data;
                off_q <= off_q + 1'b1;
            end else if (ram_ready) begin
                ram_we_q <= 1'b0;
            end
        end
    end

    sbl_fifo #(
        .W(`SBL_FIFO_W),
        .D(`SBL_FIFO_D),
        .AW(5)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_rdy),
        .in_data(rx_sh_q),
        .out_valid(fifo_out_vld),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ==========================================================
    // Outputs
    assign serial_channel_zero_txd = txd_q;
    assign ram_we = ram_we_q;
    assign ram_addr = ram_addr_q;
    assign ram_wdata = ram_wdata_q;
    assign single_boot_mode = single_q;
    assign user_boot_mode = user_q;
    assign boot_rom_map = single_q & (st_q != ST_RUN);
    assign flash_remap = single_q;
    assign flash_normal_mode = ~user_q;
    assign irq_global_disable = irq_off_q;
    assign flash_protect_req = protect_q;
    assign ram_exec_start = (st_q == ST_RUN);
    assign loader_abort = (st_q == ST_ABORT);

endmodule
`default_nettype wire

//--- verif/sbl_loader_asserts.sv
// Port checker for the serial boot loader
`timescale 1ns/100ps
`default_nettype none
module sbl_loader_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Watched ports
    input wire logic flash_busy,
    input wire logic prog_complete,
    input wire logic ram_we,
    input wire logic [31:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic ram_ready,
    input wire logic single_boot_mode,
    input wire logic user_boot_mode,
    input wire logic boot_rom_map,
    input wire logic flash_remap,
    input wire logic flash_normal_mode,
    input wire logic irq_global_disable,
    input wire logic flash_protect_req,
    input wire logic ram_exec_start,
    input wire logic loader_abort
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ====
    // RAM write steps
    sequence s_take; ram_we && ram_ready; endsequence
    sequence s_wait; ram_we && !ram_ready; endsequence
    a_rom_map: assert property (
        flash_remap == single_boot_mode && boot_rom_map == (single_boot_mode && !ram_exec_start))
        else $error("map wrong");
    // Straps land one edge after release
    a_mode_held: assert property (
        !$past(rst) && !$past(rst, 2) |-> $stable(single_boot_mode) && $stable(user_boot_mode))
        else $error("mode moved");
    a_exec_sticky: assert property (ram_exec_start |=> ram_exec_start)
        else $error("exec dropped");
    a_irq_masked: assert property (flash_busy || user_boot_mode |=> irq_global_disable)
        else $error("irq open");
    a_flash_normal: assert property (flash_normal_mode == !user_boot_mode)
        else $error("flash mode");
    a_protect_sticky: assert property (prog_complete || flash_protect_req |=> flash_protect_req)
        else $error("protect lost");
    a_word_holds: assert property (
        s_wait |=> loader_abort || (ram_we && $stable(ram_addr) && $stable(ram_wdata)))
        else $error("word moved");
    a_addr_steps: assert property (s_take ##1 ram_we |-> ram_addr == $past(ram_addr) + 32'h1)
        else $error("addr step");
endmodule
bind sbl_loader sbl_loader_asserts chk_u (.core_clk(core_clk), .rst(rst), .flash_busy(flash_busy),
    .prog_complete(prog_complete), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_ready(ram_ready), .single_boot_mode(single_boot_mode), .user_boot_mode(user_boot_mode),
    .boot_rom_map(boot_rom_map), .flash_remap(flash_remap), .flash_normal_mode(flash_normal_mode),
    .irq_global_disable(irq_global_disable), .flash_protect_req(flash_protect_req),
    .ram_exec_start(ram_exec_start), .loader_abort(loader_abort));
`default_nettype wire

//--- verif/sbl_host_model.sv
// Host model on serial channel zero
`timescale 1ns/100ps
`default_nettype none
module sbl_host_model #(parameter int BITP = 8) (
    // Clock
    input wire logic core_clk,
    // Serial channel zero
    output logic rxd,
    input wire logic txd
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial rxd = 1'b1;
    // ====
    // Start, 8 data LSB first, no parity, 1 stop
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            #1;
            rxd = fr[i];
            repeat (BITP - 1) @(posedge core_clk);
        end
    endtask
    // Byte is queued only once its stop bit is over
    always begin
        @(negedge txd);
        repeat (BITP / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BITP) @(posedge core_clk);
            sh[i] = txd;
        end
        repeat (BITP + BITP / 2) @(posedge core_clk);
        rx_q.push_back(sh);
    end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the serial boot loader
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sel_n = 1'b0;
    logic ucond = 1'b0;
    logic erased = 1'b0;
    logic busy = 1'b0;
    logic done = 1'b0;
    logic ram_ready = 1'b0;
    logic stall = 1'b0;
    logic [95:0] flash_pw = 96'h0;
    logic [15:0] flash_sum = 16'h0;
    logic [31:0] seed = 32'h31B9F579;
    logic [31:0] r;
    logic [31:0] exp_addr = 32'h0;
    logic [2:0] cyc = 3'h0;
    logic [7:0] dq[$];
    int fails = 0;
    int n_tests = 0;
    wire rxd, txd, ram_we, sb, ub, rom_map, remap, normal, irq_off, protect, exec, abort;
    wire [31:0] ram_addr;
    wire [7:0] ram_wdata;
    always #2.5 core_clk = ~core_clk;
    sbl_loader dut_u (.core_clk(core_clk), .rst(rst), .boot_sel_n(sel_n), .user_boot_cond(ucond),
        .serial_channel_zero_rxd(rxd), .serial_channel_zero_txd(txd), .flash_pw(flash_pw),
        .pw_block_erased(erased), .flash_sum(flash_sum), .flash_busy(busy), .prog_complete(done),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ready(ram_ready),
        .single_boot_mode(sb), .user_boot_mode(ub), .boot_rom_map(rom_map), .flash_remap(remap),
        .flash_normal_mode(normal), .irq_global_disable(irq_off), .flash_protect_req(protect),
        .ram_exec_start(exec), .loader_abort(abort));
    sbl_host_model #(.BITP(8)) host_u (.core_clk(core_clk), .rxd(rxd), .txd(txd));
    // ====
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset(input logic s, input logic c);
        @(posedge core_clk);
        #1;
        rst = 1'b1;
        sel_n = s;
        ucond = c;
        repeat (10) @(posedge core_clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        host_u.rx_q.delete();
        dq.delete();
    endtask
    task automatic expect_rx(input logic [7:0] b);
        int t;
        for (t = 0; t < 400 && host_u.rx_q.size() == 0; t++) @(posedge core_clk);
        check(host_u.rx_q.size() > 0 ? host_u.rx_q.pop_front() : 8'hXX, b);
    endtask
    task automatic xfer(input logic [7:0] c, input logic [23:0] rep, input int k);
        host_u.send(c);
        for (int i = 0; i < k; i++) expect_rx(rep[23-8*i -: 8]);
    endtask
    task automatic session(input logic er, input logic good, input int n, input logic hold);
        logic [95:0] pw;
        logic [47:0] hdr;
        logic [7:0] sum;
        int t;
        pw = er ? {12{8'hFF}} : flash_pw ^ {95'h0, !good};
        hdr = {32'hFFFD6000, n[15:0]};
        sum = 8'h00;
        erased = er;
        stall = hold;
        exp_addr = hdr[47:16];
        xfer(8'h86, 24'h860000, 1);
        xfer(8'h10, 24'h100000, 1);
        for (int i = 0; i < 12; i++) begin
            host_u.send(pw[8*i +: 8]);
            sum = sum + pw[8*i +: 8];
        end
        host_u.send(8'h00 - sum);
        if (good) begin
            expect_rx(8'h10);
            for (int i = 0; i < 6; i++) host_u.send(hdr[47-8*i -: 8]);
            for (int i = 0; i < n; i++) begin
                r = rnd();
                dq.push_back(r[7:0]);
                host_u.send(r[7:0]);
            end
        end
        for (t = 0; t < 600 && exec !== 1'b1 && abort !== 1'b1; t++) @(posedge core_clk);
        #1;
        check({exec, abort, rom_map}, good && !hold ? 3'h4 : 3'h3);
        check(host_u.rx_q.size(), 0);
        if (good && !hold) check(dq.size(), 0);
    endtask
    // ====
    // RAM side: slow at times, or stalled to overfill the FIFO
    always @(posedge core_clk) begin
        #1;
        cyc = cyc + 3'h1;
        ram_ready = !stall && (cyc[0] || cyc[2]);
    end
    always @(posedge core_clk) begin
        if (ram_we === 1'b1 && ram_ready === 1'b1) begin
            check(ram_addr, exp_addr);
            check({24'h0, ram_wdata}, {24'h0, dq.size() > 0 ? dq.pop_front() : 8'hXX});
            exp_addr = exp_addr + 32'h1;
        end
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        fails++;
        test_done();
    end
    initial begin
        flash_pw = {rnd(), rnd(), rnd()};
        r = rnd();
        flash_sum = r[15:0];
        do_reset(1'b0, 1'b0);
        sel_n = 1'b1;
        check({sb, ub, remap, rom_map, normal, irq_off}, 6'h2E);
        xfer(8'h86, 24'h860000, 1);
        xfer(8'h20, {8'h20, flash_sum}, 3);
        xfer(8'h30, 24'h305A00, 2);
        xfer(8'h55, 24'h510000, 1);
        xfer(8'h10, 24'h100000, 1);
        repeat (13) host_u.send(8'h01);
        expect_rx(8'h11);
        do_reset(1'b0, 1'b0);
        session(1'b0, 1'b1, 5, 1'b0);
        busy = 1'b1;
        done = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check({irq_off, protect, sb}, 3'h7);
        busy = 1'b0;
        done = 1'b0;
        do_reset(1'b0, 1'b0);
        session(1'b1, 1'b1, 0, 1'b0);
        do_reset(1'b0, 1'b0);
        session(1'b0, 1'b0, 3, 1'b0);
        do_reset(1'b0, 1'b0);
        session(1'b0, 1'b1, 40, 1'b1);
        do_reset(1'b1, 1'b1);
        check({sb, ub, normal, irq_off}, 4'h5);
        do_reset(1'b1, 1'b0);
        check({sb, ub, normal, protect}, 4'h2);
        test_done();
    end
endmodule
`default_nettype wire
